//--- core/vcfm_pkg.sv
// package of the vibration channel fault monitor: register map, field layout,
// reset values, mode codes, carrier structs and timing constants.
// assumes a 250 MHz system clock.
package vcfm_pkg;

  localparam int unsigned NUM_CH = 8;
  localparam int unsigned CH_PER_PAIR = 2;
  localparam int unsigned NUM_PAIRS = NUM_CH / CH_PER_PAIR;
  localparam int unsigned NUM_PROG = 4;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_UPDATE = 8'h10;

  // status word fields
  localparam int unsigned ST_VALID_LSB = 0;
  localparam int unsigned ST_OPEN_LSB = 8;
  localparam int unsigned ST_SHORT_LSB = 16;
  localparam int unsigned ST_SUPPLY_LSB = 24;

  // interrupt status fields
  localparam int unsigned IRQ_OPEN_LSB = 0;
  localparam int unsigned IRQ_SHORT_LSB = 8;
  localparam int unsigned IRQ_VLOST_LSB = 16;
  localparam int unsigned IRQ_UPD_DONE_BIT = 24;
  localparam int unsigned IRQ_W = 25;

  // update word fields
  localparam int unsigned UPD_RUN_BIT = 0;
  localparam int unsigned UPD_GREEN_BIT = 1;

  localparam int unsigned MODE_FIELD_W = 2;
  localparam int unsigned MODE_REG_W = NUM_PAIRS * MODE_FIELD_W;
  localparam logic [MODE_REG_W-1:0] MODE_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 25'h0000000;

  typedef enum logic [1:0] {
    MODE_SUPPLY = 2'h0,
    MODE_AC = 2'h1,
    MODE_DC = 2'h2
  } vcfm_mode_e;

  // timing
  localparam longint unsigned CLK_HZ = 64'd250_000_000;
  localparam longint unsigned FAULT_DELAY_S = 64'd10;
  localparam longint unsigned FAULT_DELAY_CYC = FAULT_DELAY_S * CLK_HZ;
  localparam longint unsigned ORANGE_STEP_MS = 64'd125;
  localparam longint unsigned GREEN_STEP_MS = 64'd250;
  localparam longint unsigned ORANGE_STEP_CYC = ORANGE_STEP_MS * CLK_HZ / 64'd1000;
  localparam longint unsigned GREEN_STEP_CYC = GREEN_STEP_MS * CLK_HZ / 64'd1000;
  localparam int unsigned CNT_W = 32;

  typedef struct packed {
    logic [NUM_CH-1:0] valid;
    logic [NUM_CH-1:0] open_line;
    logic [NUM_CH-1:0] shorted;
  } vcfm_flags_s;

  typedef struct packed {
    logic [NUM_PROG-1:0] orange;
    logic [NUM_PROG-1:0] green;
  } vcfm_prog_s;

endpackage : vcfm_pkg

//--- core/vcfm_fault_delay.sv
// one delayed fault flag: follows its condition only after the condition
// has differed from the flag for a full uninterrupted delay.
// assumes a synchronous active-high reset and a clear that holds it off.
`timescale 1ns/1ps
`default_nettype none
module vcfm_fault_delay #(
  parameter logic [vcfm_pkg::CNT_W-1:0] DELAY_CYC = 32'h9502F900
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // condition
  input wire logic i_clear,
  input wire logic i_cond,
  // flag
  output logic o_flag
);

  logic [vcfm_pkg::CNT_W-1:0] cnt_r;
  logic [vcfm_pkg::CNT_W-1:0] cnt_nxt;
  logic flag_r;
  logic flag_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    flag_nxt = flag_r;
    if (i_clear) begin
      cnt_nxt = '0;
      flag_nxt = 1'b0;
    end else if (i_cond == flag_r) begin
      cnt_nxt = '0;
    end else if (cnt_r >= DELAY_CYC - 32'h1) begin
      cnt_nxt = '0;
      flag_nxt = i_cond;
    end else begin
      cnt_nxt = cnt_r + 32'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_r <= '0;
      flag_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign o_flag = flag_r;

endmodule // vcfm_fault_delay
`default_nettype wire

//--- core/vcfm_progress.sv
// update progress sequencer: four indicators lit one after another,
// orange at a fast step, then green at a slower step.
// assumes run and green phase are levels from the backplane side.
`timescale 1ns/1ps
`default_nettype none
module vcfm_progress #(
  parameter logic [vcfm_pkg::CNT_W-1:0] ORANGE_CYC = 32'h01DCD650,
  parameter logic [vcfm_pkg::CNT_W-1:0] GREEN_CYC = 32'h03B9ACA0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // update state
  input wire logic i_run,
  input wire logic i_green,
  // indicators
  output vcfm_pkg::vcfm_prog_s o_leds
);

  typedef enum logic [1:0] {PG_IDLE, PG_ORANGE, PG_GREEN} vcfm_pg_e;

  vcfm_pg_e st_r;
  vcfm_pg_e st_nxt;
  logic [vcfm_pkg::CNT_W-1:0] cnt_r;
  logic [vcfm_pkg::CNT_W-1:0] cnt_nxt;
  logic [1:0] idx_r;
  logic [1:0] idx_nxt;
  vcfm_pkg::vcfm_prog_s leds_r;
  vcfm_pkg::vcfm_prog_s leds_nxt;
  logic [vcfm_pkg::CNT_W-1:0] period;
  logic [vcfm_pkg::NUM_PROG-1:0] onehot;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    idx_nxt = idx_r;
    leds_nxt = '0;
    period = (st_r == PG_GREEN) ? GREEN_CYC : ORANGE_CYC;
    onehot = 4'h1 << idx_r;
    unique case (st_r)
      PG_IDLE: begin
        if (i_run) begin
          st_nxt = i_green ? PG_GREEN : PG_ORANGE;
        end
      end
      PG_ORANGE, PG_GREEN: begin
        // lit in the first half of its step, which makes it flash
        if (cnt_r < (period >> 1)) begin
          if (st_r == PG_GREEN) begin
            leds_nxt.green = onehot;
          end else begin
            leds_nxt.orange = onehot;
          end
        end
        if (cnt_r >= period - 32'h1) begin
          cnt_nxt = '0;
          idx_nxt = idx_r + 2'h1;
        end else begin
          cnt_nxt = cnt_r + 32'h1;
        end
        if (!i_run) begin
          st_nxt = PG_IDLE;
        end else if (i_green && st_r == PG_ORANGE) begin
          st_nxt = PG_GREEN;
        end
      end
    endcase
    // every phase starts again with the first indicator
    if (st_nxt != st_r) begin
      cnt_nxt = '0;
      idx_nxt = 2'h0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= PG_IDLE;
      cnt_r <= '0;
      idx_r <= 2'h0;
      leds_r <= '0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      idx_r <= idx_nxt;
      leds_r <= leds_nxt;
    end
  end

  assign o_leds = leds_r;

endmodule // vcfm_progress
`default_nettype wire

//--- core/vcfm_top.sv
// top of the vibration channel fault monitor: per-channel valid and
// delayed fault flags, mode register, interrupts and update indicators.
// assumes synchronous inputs from the analog front end and the backplane.
`timescale 1ns/1ps
`default_nettype none
// Function
// - eight channels, grouped as isolated pairs
// - first of pair always sensor supply
// - valid always, faults only in supply
// - valid only after settling finished
// - supply mode fault drops valid
// - one open-line flag, broken or absent
// - supply above 20 V, flag after 10 s
// - supply below 20 V, clear after 10 s
// - short present, flag after 10 s
// - short removed, clear after 10 s
// - four indicators step, orange then green
// - reboot by itself after update
module vcfm_top #(
  parameter logic [vcfm_pkg::CNT_W-1:0] FAULT_CYC =
    vcfm_pkg::CNT_W'(vcfm_pkg::FAULT_DELAY_CYC),
  parameter logic [vcfm_pkg::CNT_W-1:0] ORANGE_CYC =
    vcfm_pkg::CNT_W'(vcfm_pkg::ORANGE_STEP_CYC),
  parameter logic [vcfm_pkg::CNT_W-1:0] GREEN_CYC =
    vcfm_pkg::CNT_W'(vcfm_pkg::GREEN_STEP_CYC)
) (
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  // register port
  input wire logic [vcfm_pkg::ADDR_W-1:0] I_REG_ADDR,
  input wire logic [vcfm_pkg::DATA_W-1:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  output logic [vcfm_pkg::DATA_W-1:0] O_REG_RDATA,
  // analog front end, one bit per channel
  input wire logic [vcfm_pkg::NUM_CH-1:0] I_CH_SETTLED,
  input wire logic [vcfm_pkg::NUM_CH-1:0] I_CH_SUPPLY_HIGH,
  input wire logic [vcfm_pkg::NUM_CH-1:0] I_CH_SHORT,
  // update control from the backplane
  input wire logic I_UPD_RUN,
  input wire logic I_UPD_GREEN,
  input wire logic I_UPD_DONE,
  // channel flags and indicators
  output vcfm_pkg::vcfm_flags_s O_CH_FLAGS,
  output vcfm_pkg::vcfm_prog_s O_PROG_LEDS,
  output logic O_REBOOT,
  output logic O_IRQ
);

  localparam int unsigned NCH = vcfm_pkg::NUM_CH;

  // a channel runs in sensor supply mode unless its pair field selects
  // an ac or dc voltage input; the first channel of a pair ignores it
  function automatic logic is_supply(input int unsigned ch,
                                     input logic [vcfm_pkg::MODE_REG_W-1:0] modes);
    logic [1:0] fld;
    fld = modes[(ch / vcfm_pkg::CH_PER_PAIR) * vcfm_pkg::MODE_FIELD_W +: 2];
    if ((ch % vcfm_pkg::CH_PER_PAIR) == 0) begin
      return 1'b1;
    end
    return !(fld == vcfm_pkg::MODE_AC || fld == vcfm_pkg::MODE_DC);
  endfunction

  function automatic logic hit(input logic [vcfm_pkg::ADDR_W-1:0] a,
                               input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // register state
  logic [vcfm_pkg::MODE_REG_W-1:0] mode_r;
  logic [vcfm_pkg::MODE_REG_W-1:0] mode_nxt;
  logic [vcfm_pkg::IRQ_W-1:0] irq_stat_r;
  logic [vcfm_pkg::IRQ_W-1:0] irq_stat_nxt;
  logic [vcfm_pkg::IRQ_W-1:0] irq_mask_r;
  logic [vcfm_pkg::IRQ_W-1:0] irq_mask_nxt;
  logic [vcfm_pkg::DATA_W-1:0] rdata_r;
  logic [vcfm_pkg::DATA_W-1:0] rdata_nxt;
  logic irq_r;
  logic irq_nxt;

  // channel state
  logic [NCH-1:0] supply;
  logic [NCH-1:0] open_flag;
  logic [NCH-1:0] short_flag;
  vcfm_pkg::vcfm_flags_s flags_r;
  vcfm_pkg::vcfm_flags_s flags_nxt;
  logic reboot_r;
  logic reboot_nxt;
  logic [vcfm_pkg::IRQ_W-1:0] events;
  logic [vcfm_pkg::IRQ_W-1:0] w1c;

  // eight channels, two per isolated pair, each with its own flags
  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    assign supply[ch] = is_supply(ch, mode_r);

    // open line covers both a broken cable and a missing sensor
    vcfm_fault_delay #(
      .DELAY_CYC(FAULT_CYC)
    ) u_open (
      .i_clk(I_SYS_CLK),
      .i_rst(I_RST),
      .i_clear(!supply[ch]),
      .i_cond(I_CH_SUPPLY_HIGH[ch]),
      .o_flag(open_flag[ch])
    );

    vcfm_fault_delay #(
      .DELAY_CYC(FAULT_CYC)
    ) u_short (
      .i_clk(I_SYS_CLK),
      .i_rst(I_RST),
      .i_clear(!supply[ch]),
      .i_cond(I_CH_SHORT[ch]),
      .o_flag(short_flag[ch])
    );
  end

  vcfm_progress #(
    .ORANGE_CYC(ORANGE_CYC),
    .GREEN_CYC(GREEN_CYC)
  ) u_prog (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_run(I_UPD_RUN),
    .i_green(I_UPD_GREEN),
    .o_leds(O_PROG_LEDS)
  );

  // channel flags, registered
  always_comb begin
    flags_nxt.open_line = open_flag & supply;
    flags_nxt.shorted = short_flag & supply;
    // valid in every mode; in supply mode a fault takes it away
    flags_nxt.valid = I_CH_SETTLED
                      & ~(supply & (open_flag | short_flag));
    reboot_nxt = I_UPD_DONE;
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      flags_r <= '0;
      reboot_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      reboot_r <= reboot_nxt;
    end
  end

  // interrupt events: fault raised, valid lost, update finished
  always_comb begin
    events = '0;
    events[vcfm_pkg::IRQ_OPEN_LSB +: NCH] = flags_nxt.open_line & ~flags_r.open_line;
    events[vcfm_pkg::IRQ_SHORT_LSB +: NCH] = flags_nxt.shorted & ~flags_r.shorted;
    events[vcfm_pkg::IRQ_VLOST_LSB +: NCH] = flags_r.valid & ~flags_nxt.valid;
    events[vcfm_pkg::IRQ_UPD_DONE_BIT] = I_UPD_DONE;
  end

  // register writes and reads
  always_comb begin
    mode_nxt = mode_r;
    irq_mask_nxt = irq_mask_r;
    w1c = '0;
    rdata_nxt = '0;
    if (I_REG_WR) begin
      if (hit(I_REG_ADDR, vcfm_pkg::OFS_MODE)) begin
        mode_nxt = I_REG_WDATA[vcfm_pkg::MODE_REG_W-1:0];
      end
      if (hit(I_REG_ADDR, vcfm_pkg::OFS_IRQ_STAT)) begin
        w1c = I_REG_WDATA[vcfm_pkg::IRQ_W-1:0];
      end
      if (hit(I_REG_ADDR, vcfm_pkg::OFS_IRQ_MASK)) begin
        irq_mask_nxt = I_REG_WDATA[vcfm_pkg::IRQ_W-1:0];
      end
    end
    // a new event outweighs a clear in the same cycle
    irq_stat_nxt = (irq_stat_r & ~w1c) | events;
    irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
    if (I_REG_RD) begin
      if (hit(I_REG_ADDR, vcfm_pkg::OFS_MODE)) begin
        rdata_nxt[vcfm_pkg::MODE_REG_W-1:0] = mode_r;
      end
      if (hit(I_REG_ADDR, vcfm_pkg::OFS_STATUS)) begin
        rdata_nxt[vcfm_pkg::ST_VALID_LSB +: NCH] = flags_r.valid;
        rdata_nxt[vcfm_pkg::ST_OPEN_LSB +: NCH] = flags_r.open_line;
        rdata_nxt[vcfm_pkg::ST_SHORT_LSB +: NCH] = flags_r.shorted;
        rdata_nxt[vcfm_pkg::ST_SUPPLY_LSB +: NCH] = supply;
      end
      if (hit(I_REG_ADDR, vcfm_pkg::OFS_IRQ_STAT)) begin
        rdata_nxt[vcfm_pkg::IRQ_W-1:0] = irq_stat_r;
      end
      if (hit(I_REG_ADDR, vcfm_pkg::OFS_IRQ_MASK)) begin
        rdata_nxt[vcfm_pkg::IRQ_W-1:0] = irq_mask_r;
      end
      if (hit(I_REG_ADDR, vcfm_pkg::OFS_UPDATE)) begin
        rdata_nxt[vcfm_pkg::UPD_RUN_BIT] = I_UPD_RUN;
        rdata_nxt[vcfm_pkg::UPD_GREEN_BIT] = I_UPD_GREEN;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      mode_r <= vcfm_pkg::MODE_RST;
      irq_stat_r <= '0;
      irq_mask_r <= vcfm_pkg::IRQ_MASK_RST;
      rdata_r <= '0;
      irq_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign O_CH_FLAGS = flags_r;
  assign O_REBOOT = reboot_r;
  assign O_IRQ = irq_r;
  assign O_REG_RDATA = rdata_r;

endmodule // vcfm_top
`default_nettype wire

//--- test/vcfm_top_asserts.sv
// checker of the fault monitor top: read data, flag delays, indicators.
// assumes it is bound into vcfm_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module vcfm_top_asserts #(
  parameter logic [31:0] FAULT_CYC = 32'h00000008
) (
  // clock, reset and inputs
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_REG_RD,
  input wire logic [7:0] I_CH_SETTLED,
  input wire logic [7:0] I_CH_SHORT,
  input wire logic I_UPD_RUN,
  input wire logic I_UPD_GREEN,
  input wire logic I_UPD_DONE,
  // outputs
  input wire logic [31:0] O_REG_RDATA,
  input wire vcfm_pkg::vcfm_flags_s O_CH_FLAGS,
  input wire vcfm_pkg::vcfm_prog_s O_PROG_LEDS,
  input wire logic O_REBOOT
);
  logic [7:0] hi_r;
  logic [7:0] lo_r;
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  // run lengths of the short condition on channel 0
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      hi_r <= 8'h00;
      lo_r <= 8'h00;
    end else begin
      hi_r <= I_CH_SHORT[0] ? hi_r + {7'h00, hi_r != 8'hFF} : 8'h00;
      lo_r <= !I_CH_SHORT[0] ? lo_r + {7'h00, lo_r != 8'hFF} : 8'h00;
    end
  end
  sequence s_run_start;
    $rose(I_UPD_RUN) && !I_UPD_GREEN;
  endsequence
  sequence s_first_lit;
    ##2 O_PROG_LEDS.orange[0];
  endsequence
  a_rdata_idle: assert property (!$past(I_REG_RD) |-> O_REG_RDATA == 32'h00000000)
    else $error("read data outside read cycle");
  a_reboot_follow: assert property ($rose(I_UPD_DONE) |=> O_REBOOT)
    else $error("no reboot after update");
  a_valid_settle: assert property ((O_CH_FLAGS.valid & ~$past(I_CH_SETTLED)) == 8'h00)
    else $error("valid before settling");
  a_short_rise: assert property ($rose(O_CH_FLAGS.shorted[0]) |->
    32'(hi_r) == FAULT_CYC + 32'h1)
    else $error("short flag rose at wrong time");
  a_short_fall: assert property ($fell(O_CH_FLAGS.shorted[0]) |->
    32'(lo_r) == FAULT_CYC + 32'h1)
    else $error("short flag fell at wrong time");
  a_valid_fault: assert property (!(O_CH_FLAGS.valid[0] &&
    (O_CH_FLAGS.shorted[0] || O_CH_FLAGS.open_line[0])))
    else $error("valid with fault");
  // the indicators go dark two edges after run drops
  a_leds_idle: assert property ((!$past(I_UPD_RUN) && !$past(I_UPD_RUN, 2)) |->
    O_PROG_LEDS == 8'h00)
    else $error("indicator lit without update");
  a_one_led: assert property ($onehot0(O_PROG_LEDS))
    else $error("more than one indicator lit");
  a_first_lit: assert property (s_run_start |-> s_first_lit)
    else $error("first indicator not lit first");
endmodule // vcfm_top_asserts
bind vcfm_top vcfm_top_asserts #(.FAULT_CYC(FAULT_CYC)) vcfm_top_asserts_i (
  .I_SYS_CLK(I_SYS_CLK),
  .I_RST(I_RST),
  .I_REG_RD(I_REG_RD),
  .I_CH_SETTLED(I_CH_SETTLED),
  .I_CH_SHORT(I_CH_SHORT),
  .I_UPD_RUN(I_UPD_RUN),
  .I_UPD_GREEN(I_UPD_GREEN),
  .I_UPD_DONE(I_UPD_DONE),
  .O_REG_RDATA(O_REG_RDATA),
  .O_CH_FLAGS(O_CH_FLAGS),
  .O_PROG_LEDS(O_PROG_LEDS),
  .O_REBOOT(O_REBOOT)
);
`default_nettype wire

//--- test/vcfm_central_model.sv
// central unit model: starts an update on a version mismatch.
// assumes one clock with the device; run, green and done are levels/pulse.
`timescale 1ns/1ps
`default_nettype none
module vcfm_central_model #(
  parameter int ORANGE_N = 32,
  parameter int GREEN_N = 64
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // request and identity
  input wire logic i_start,
  input wire logic i_known,
  input wire logic [7:0] i_mod_ver,
  input wire logic [7:0] i_rel_ver,
  // update control
  output logic o_run,
  output logic o_green,
  output logic o_done
);
  int cnt_r;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_run <= 1'b0;
      o_green <= 1'b0;
      o_done <= 1'b0;
      cnt_r <= 0;
    end else begin
      o_done <= 1'b0;
      if (!o_run) begin
        // unknown types are left alone, matching versions need nothing
        if (i_start && i_known && i_mod_ver != i_rel_ver) begin
          o_run <= 1'b1;
          cnt_r <= 0;
        end
      end else begin
        cnt_r <= cnt_r + 1;
        if (cnt_r == ORANGE_N - 1) begin
          o_green <= 1'b1;
        end
        if (cnt_r == ORANGE_N + GREEN_N - 1) begin
          o_run <= 1'b0;
          o_green <= 1'b0;
          o_done <= 1'b1;
        end
      end
    end
  end
endmodule // vcfm_central_model
`default_nettype wire

//--- test/vcfm_top_tb.sv
// testbench of the fault monitor top: registers, flags, interrupts, update.
// assumes short delay parameters and the central unit model.
`timescale 1ns/1ps
`default_nettype none
module vcfm_top_tb;
  logic clk;
  logic rst;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic [7:0] settled;
  logic [7:0] sup_hi;
  logic [7:0] short_in;
  logic start;
  logic known;
  logic [7:0] rel_ver;
  logic [7:0] mod_ver;
  logic run;
  logic green;
  logic done;
  logic reboot;
  logic irq;
  vcfm_pkg::vcfm_flags_s flags;
  vcfm_pkg::vcfm_prog_s leds;
  int bad_count;
  int checks;
  int i;
  vcfm_top #(.FAULT_CYC(32'h00000008), .ORANGE_CYC(32'h00000008),
    .GREEN_CYC(32'h00000010)) vcfm_top_i (
    .I_SYS_CLK(clk), .I_RST(rst), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
    .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata), .I_CH_SETTLED(settled),
    .I_CH_SUPPLY_HIGH(sup_hi), .I_CH_SHORT(short_in), .I_UPD_RUN(run),
    .I_UPD_GREEN(green), .I_UPD_DONE(done), .O_CH_FLAGS(flags),
    .O_PROG_LEDS(leds), .O_REBOOT(reboot), .O_IRQ(irq));
  vcfm_central_model #(.ORANGE_N(32), .GREEN_N(64)) vcfm_central_model_i (
    .i_clk(clk), .i_rst(rst), .i_start(start), .i_known(known),
    .i_mod_ver(mod_ver), .i_rel_ver(rel_ver), .o_run(run), .o_green(green), .o_done(done));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic pulse_start(input logic k, input logic [7:0] m, input logic [7:0] v);
    @(posedge clk);
    known <= k;
    mod_ver <= m;
    rel_ver <= v;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask
  task automatic end_of_test;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    end_of_test;
  end
  initial begin
    {rst, addr, wdata, wr, rd, sup_hi, short_in, start, known, rel_ver, mod_ver} = '0;
    rst = 1'b1;
    settled = 8'h0F;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_reg(8'h00, 32'h00000000);
    rd_reg(8'h0C, 32'h00000000);
    rd_reg(8'h08, 32'h00000000);
    rd_reg(8'h04, 32'hFF00000F);
    rd_reg(8'h14, 32'h00000000);
    wr_reg(8'h00, 32'h00000039);
    rd_reg(8'h00, 32'h00000039);
    @(posedge clk);
    settled <= 8'hFF;
    rd_reg(8'h04, 32'hF50000FF);
    wr_reg(8'h0C, 32'h01FFFFFF);
    @(posedge clk);
    short_in <= 8'hFF;
    repeat (7) @(posedge clk);
    short_in <= 8'h00;
    wait_cyc(12);
    chk(32'(flags), 32'h00FF0000);
    @(posedge clk);
    short_in <= 8'hFF;
    wait_cyc(11);
    chk(32'(flags), 32'h000A00F5);
    chk(32'(irq), 32'h00000001);
    rd_reg(8'h08, 32'h00F5F500);
    wr_reg(8'h08, 32'h00F5F500);
    rd_reg(8'h08, 32'h00000000);
    chk(32'(irq), 32'h00000000);
    @(posedge clk);
    short_in <= 8'h00;
    wait_cyc(11);
    chk(32'(flags), 32'h00FF0000);
    wr_reg(8'h0C, 32'h00000000);
    @(posedge clk);
    sup_hi <= 8'h03;
    wait_cyc(11);
    chk(32'(flags), 32'h00FE0100);
    chk(32'(irq), 32'h00000000);
    wr_reg(8'h0C, 32'h01FFFFFF);
    wait_cyc(1);
    chk(32'(irq), 32'h00000001);
    rd_reg(8'h08, 32'h00010001);
    @(posedge clk);
    sup_hi <= 8'h00;
    wait_cyc(11);
    chk(32'(flags), 32'h00FF0000);
    wr_reg(8'h08, 32'h01FFFFFF);
    pulse_start(1'b0, 8'h11, 8'h12);
    rd_reg(8'h10, 32'h00000000);
    pulse_start(1'b1, 8'h11, 8'h11);
    rd_reg(8'h10, 32'h00000000);
    pulse_start(1'b1, 8'h12, 8'h11);
    rd_reg(8'h10, 32'h00000001);
    chk(32'(leds), 32'h00000010);
    wait_cyc(38);
    chk(32'(leds), 32'h00000001);
    rd_reg(8'h10, 32'h00000003);
    i = 0;
    while (reboot !== 1'b1 && i < 200) begin
      @(negedge clk);
      i++;
    end
    chk(32'(reboot), 32'h00000001);
    rd_reg(8'h08, 32'h01000000);
    end_of_test;
  end
endmodule // vcfm_top_tb
`default_nettype wire
